// *** design/isrp_status_rx.v ***
/*
 * Status flags, acknowledge control and receive holding buffer of an I2C
 * bus interface, with a small bus observer that produces the frame events.
 * Assumes SCL is driven by the bus or by the clock generator elsewhere and
 * that start issue and arbitration loss arrive as one-cycle pulses on ref_clk.
 */
// Overview of operation
// R1 - The empty flag sets when a byte moves to the shift stage, on transmit select, or on start.
// R2 - The empty flag clears on a zero write after a read of one, or on a transmit buffer write.
// R3 - The end flag sets at the ninth SCL rising edge of each byte when the empty flag is one.
// R4 - The end flag clears on a zero write after a read of one, or on a transmit buffer write.
// R5 - The full flag sets when a received byte is copied into the receive holding buffer.
// R6 - The full flag clears on a receive buffer read, or on a zero write after a read of one.
// R7 - The stop flag sets on a stop after at least one full byte and clears only on a zero write after a read.
// R8 - While receiving, the acknowledge slot carries the value of the acknowledge select bit.
// R9 - An 8-bit receive holding buffer keeps each byte so the shift stage can take the next.
// R10 - The receive holding buffer ignores writes and resets to all ones.
// R11 - The master and transmit select bits choose among the four operating roles.
// R12 - Arbitration loss as master clears both select bits, giving slave receive.
// R13 - A written zero clears a flag only if software read that flag as one beforehand.
// R14 - A setting event in the same cycle as a clear wins, so no event is lost.
`timescale 1ns/100ps
`include "isrp_consts.vh"
module isrp_status_rx
(
	input wire ref_clk,
	input wire rst,
	input wire [`ISRP_ADDR_W-1:0] addr,
	input wire [`ISRP_DATA_W-1:0] wdata,
	input wire wr,
	input wire rd,
	output wire [`ISRP_DATA_W-1:0] rdata,
	input wire scl_in,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe_n,
	input wire start_issued,
	input wire arb_lost,
	output wire [1:0] role_select,
	output wire irq
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation and bus condition detection.
	wire [1:0] pins_clean;
	reg scl_prev_q;
	reg sda_prev_q;
	wire scl_now;
	wire sda_now;
	wire scl_rise;
	wire scl_fall;
	wire bus_start;
	wire bus_stop;

	isrp_pin_sync #(.WIDTH(2), .RST_VAL(2'b11)) u_pin_sync
	(
		.ref_clk(ref_clk),
		.rst(rst),
		.pin_in({scl_in, sda_in}),
		.pin_clean(pins_clean)
	);

	assign scl_now = pins_clean[1];
	assign sda_now = pins_clean[0];
	assign scl_rise = scl_now & ~scl_prev_q;
	assign scl_fall = ~scl_now & scl_prev_q;
	assign bus_start = scl_now & scl_prev_q & sda_prev_q & ~sda_now;
	assign bus_stop = scl_now & scl_prev_q & ~sda_prev_q & sda_now;

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end
		else
		begin
			scl_prev_q <= scl_now;
			sda_prev_q <= sda_now;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register access decode.
	wire wr_ctrl = wr & (addr == `ISRP_OFF_CTRL);
	wire wr_irq_en = wr & (addr == `ISRP_OFF_IRQ_EN);
	wire wr_status = wr & (addr == `ISRP_OFF_STATUS);
	wire wr_tx_hold = wr & (addr == `ISRP_OFF_TX_HOLD);
	wire rd_status = rd & (addr == `ISRP_OFF_STATUS);
	wire rd_rx_hold = rd & (addr == `ISRP_OFF_RX_HOLD);

	reg [`ISRP_DATA_W-1:0] ctrl_q;
	reg [`ISRP_DATA_W-1:0] irq_en_q;
	reg [`ISRP_DATA_W-1:0] tx_hold_q;
	reg [`ISRP_DATA_W-1:0] rx_hold_q;
	reg [`ISRP_DATA_W-1:0] rdata_q;
	reg [3:0] flag_q;
	reg [3:0] armed_q;
	reg [3:0] flag_set;
	reg [3:0] flag_hw_clr;
	wire [3:0] flag_wbit;
	wire [`ISRP_DATA_W-1:0] status_view;

	wire master_q = ctrl_q[`ISRP_BIT_MASTER];
	wire trs_q = ctrl_q[`ISRP_BIT_TRS];
	wire ack_sel = irq_en_q[`ISRP_BIT_ACK_SEL];

	// Role encoding is {master, transmit}: 00 slave rx, 01 slave tx, 10 master rx, 11 master tx.
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			ctrl_q <= `ISRP_CTRL_RST;
		else if (arb_lost & master_q)
		begin
			ctrl_q[`ISRP_BIT_MASTER] <= 1'b0; // R12
			ctrl_q[`ISRP_BIT_TRS] <= 1'b0; // R12
		end
		else if (wr_ctrl)
			ctrl_q <= wdata; // R11
	end

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			irq_en_q <= `ISRP_IRQ_EN_RST;
		else if (wr_irq_en)
			irq_en_q <= wdata;
	end

	////////////////////////////////////////////////////////////////////////////
	// Frame tracking, shift stage and acknowledge drive.
	reg in_frame_q;
	reg byte_seen_q;
	reg [3:0] bit_cnt_q;
	reg [`ISRP_DATA_W-1:0] rx_shift_q;
	reg [`ISRP_DATA_W-1:0] tx_shift_q;
	reg rx_pend_q;
	reg sda_oe_n_q;
	reg sda_out_q;
	wire [`ISRP_DATA_W-1:0] rx_shift_next = {rx_shift_q[`ISRP_DATA_W-2:0], sda_now};
	wire [3:0] bit_cnt_inc = bit_cnt_q + 4'h1;
	wire byte_rx_done = in_frame_q & scl_rise & ~trs_q & (bit_cnt_inc == `ISRP_BITS_PER_BYTE);
	wire ninth_rise = in_frame_q & scl_rise & (bit_cnt_inc == `ISRP_ACK_PULSE);
	wire tx_load = in_frame_q & scl_fall & trs_q & ~flag_q[`ISRP_FLAG_TX_EMPTY]
		& ((bit_cnt_q == 4'h0) | (bit_cnt_q == `ISRP_ACK_PULSE));
	wire rx_to_hold = (byte_rx_done & (~flag_q[`ISRP_FLAG_RX_FULL] | rd_rx_hold))
		| (rx_pend_q & rd_rx_hold);
	wire [`ISRP_DATA_W-1:0] rx_src = rx_pend_q ? rx_shift_q : rx_shift_next;

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			in_frame_q <= 1'b0;
			byte_seen_q <= 1'b0;
			bit_cnt_q <= 4'h0;
		end
		else if (bus_start)
		begin
			in_frame_q <= 1'b1;
			bit_cnt_q <= 4'h0;
		end
		else if (bus_stop)
		begin
			in_frame_q <= 1'b0;
			byte_seen_q <= 1'b0;
			bit_cnt_q <= 4'h0;
		end
		else if (in_frame_q & scl_rise)
		begin
			bit_cnt_q <= bit_cnt_inc;
			if (bit_cnt_inc == `ISRP_ACK_PULSE)
				byte_seen_q <= 1'b1;
		end
		else if (in_frame_q & scl_fall & (bit_cnt_q == `ISRP_ACK_PULSE))
			bit_cnt_q <= 4'h0;
	end

	// The shift stage keeps a byte that found the holding buffer full until it is read.
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			rx_shift_q <= `ISRP_RX_HOLD_RST;
			rx_pend_q <= 1'b0;
		end
		else
		begin
			if (in_frame_q & scl_rise & ~trs_q & (bit_cnt_inc <= `ISRP_BITS_PER_BYTE) & ~rx_pend_q)
				rx_shift_q <= rx_shift_next;
			if (byte_rx_done & flag_q[`ISRP_FLAG_RX_FULL] & ~rd_rx_hold)
				rx_pend_q <= 1'b1;
			else if (rd_rx_hold)
				rx_pend_q <= 1'b0;
		end
	end

	// The holding buffer has no write path from the register port.
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			rx_hold_q <= `ISRP_RX_HOLD_RST; // R10
		else if (rx_to_hold)
			rx_hold_q <= rx_src; // R9
	end

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			tx_hold_q <= `ISRP_TX_HOLD_RST;
		else if (wr_tx_hold)
			tx_hold_q <= wdata;
	end

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			tx_shift_q <= `ISRP_TX_HOLD_RST;
		else if (tx_load)
			tx_shift_q <= tx_hold_q;
		else if (in_frame_q & scl_fall & trs_q & (bit_cnt_q != 4'h0)
			& (bit_cnt_q < `ISRP_BITS_PER_BYTE))
			tx_shift_q <= {tx_shift_q[`ISRP_DATA_W-2:0], 1'b1};
	end

	// The pin is open drain: it is pulled low with the enable low, otherwise released.
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			sda_oe_n_q <= 1'b1;
			sda_out_q <= 1'b0;
		end
		else
		begin
			sda_out_q <= 1'b0;
			if (~in_frame_q | bus_stop | bus_start)
				sda_oe_n_q <= 1'b1;
			else if (scl_fall)
			begin
				if (bit_cnt_q == `ISRP_BITS_PER_BYTE)
					sda_oe_n_q <= trs_q | ack_sel; // R8
				else if (trs_q & tx_load)
					sda_oe_n_q <= tx_hold_q[`ISRP_DATA_W-1];
				else if (trs_q & (bit_cnt_q != 4'h0) & (bit_cnt_q < `ISRP_BITS_PER_BYTE))
					sda_oe_n_q <= tx_shift_q[`ISRP_DATA_W-2];
				else
					sda_oe_n_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status flags with read-then-write-zero clearing.
	reg trs_rise;
	always @*
	begin
		trs_rise = wr_ctrl & wdata[`ISRP_BIT_TRS] & ~trs_q;
		flag_set = 4'h0;
		flag_hw_clr = 4'h0;
		flag_set[`ISRP_FLAG_TX_EMPTY] = tx_load | trs_rise | start_issued; // R1
		flag_set[`ISRP_FLAG_TX_END] = ninth_rise & flag_q[`ISRP_FLAG_TX_EMPTY]; // R3
		flag_set[`ISRP_FLAG_RX_FULL] = rx_to_hold; // R5
		flag_set[`ISRP_FLAG_STOP] = bus_stop & byte_seen_q; // R7
		flag_hw_clr[`ISRP_FLAG_TX_EMPTY] = wr_tx_hold; // R2
		flag_hw_clr[`ISRP_FLAG_TX_END] = wr_tx_hold; // R4
		flag_hw_clr[`ISRP_FLAG_RX_FULL] = rd_rx_hold; // R6
	end

	assign flag_wbit = {wdata[`ISRP_BIT_TX_EMPTY], wdata[`ISRP_BIT_TX_END],
		wdata[`ISRP_BIT_RX_FULL], wdata[`ISRP_BIT_STOP]};

	genvar f;
	generate
		for (f = 0; f < 4; f = f + 1)
		begin : g_flag
			wire sw_clr = wr_status & ~flag_wbit[f] & armed_q[f]; // R13

			always @(posedge ref_clk or posedge rst)
			begin
				if (rst)
				begin
					flag_q[f] <= 1'b0;
					armed_q[f] <= 1'b0;
				end
				else
				begin
					flag_q[f] <= flag_set[f] | (flag_q[f] & ~(sw_clr | flag_hw_clr[f])); // R14
					if (rd_status & flag_q[f])
						armed_q[f] <= 1'b1; // R13
					else if (wr_status | ~flag_q[f])
						armed_q[f] <= 1'b0;
				end
			end
		end
	endgenerate

	assign status_view = {flag_q[`ISRP_FLAG_TX_EMPTY], flag_q[`ISRP_FLAG_TX_END],
		flag_q[`ISRP_FLAG_RX_FULL], 1'b0, flag_q[`ISRP_FLAG_STOP], 3'b000};

	////////////////////////////////////////////////////////////////////////////
	// Read data and interrupt output.
	reg [`ISRP_DATA_W-1:0] rd_mux;
	reg irq_q;

	always @*
	begin
		case (addr)
			`ISRP_OFF_CTRL: rd_mux = ctrl_q;
			`ISRP_OFF_IRQ_EN: rd_mux = irq_en_q;
			`ISRP_OFF_STATUS: rd_mux = status_view;
			`ISRP_OFF_TX_HOLD: rd_mux = tx_hold_q;
			`ISRP_OFF_RX_HOLD: rd_mux = rx_hold_q;
			default: rd_mux = `ISRP_READ_ZERO;
		endcase
	end

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			rdata_q <= `ISRP_READ_ZERO;
			irq_q <= 1'b0;
		end
		else
		begin
			rdata_q <= rd ? rd_mux : `ISRP_READ_ZERO;
			irq_q <= |(status_view & irq_en_q & 8'hf8);
		end
	end

	assign rdata = rdata_q;
	assign irq = irq_q;
	assign sda_out = sda_out_q;
	assign sda_oe_n = sda_oe_n_q;
	assign role_select = {ctrl_q[`ISRP_BIT_MASTER], ctrl_q[`ISRP_BIT_TRS]};

endmodule

// *** design/isrp_consts.vh ***
/*
 * Register offsets, field positions and reset values of the status and
 * receive path block. Included by bare name by the status and receive module only, not by the pin synchroniser.
 */
`ifndef ISRP_CONSTS_VH
`define ISRP_CONSTS_VH

`define ISRP_ADDR_W 16
`define ISRP_DATA_W 8

`define ISRP_OFF_CTRL 16'hf078
`define ISRP_OFF_IRQ_EN 16'hf07b
`define ISRP_OFF_STATUS 16'hf07c
`define ISRP_OFF_TX_HOLD 16'hf07e
`define ISRP_OFF_RX_HOLD 16'hf07f

`define ISRP_BIT_MASTER 5
`define ISRP_BIT_TRS 4
`define ISRP_BIT_ACK_SEL 0

`define ISRP_BIT_TX_EMPTY 7
`define ISRP_BIT_TX_END 6
`define ISRP_BIT_RX_FULL 5
`define ISRP_BIT_STOP 3

`define ISRP_FLAG_STOP 0
`define ISRP_FLAG_RX_FULL 1
`define ISRP_FLAG_TX_END 2
`define ISRP_FLAG_TX_EMPTY 3

`define ISRP_RX_HOLD_RST 8'hff
`define ISRP_TX_HOLD_RST 8'hff
`define ISRP_CTRL_RST 8'h00
`define ISRP_IRQ_EN_RST 8'h00
`define ISRP_READ_ZERO 8'h00

`define ISRP_BITS_PER_BYTE 4'h8
`define ISRP_ACK_PULSE 4'h9

`endif

// *** design/isrp_pin_sync.v ***
/*
 * Three-stage synchroniser with an agreement filter for bus pin inputs.
 * Assumes the inputs are asynchronous to ref_clk.
 */
`timescale 1ns/100ps
module isrp_pin_sync
#(
	parameter WIDTH = 2,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
)
(
	input wire ref_clk,
	input wire rst,
	input wire [WIDTH-1:0] pin_in,
	output wire [WIDTH-1:0] pin_clean
);

	reg [WIDTH-1:0] st1_q;
	reg [WIDTH-1:0] st2_q;
	reg [WIDTH-1:0] st3_q;
	reg [WIDTH-1:0] clean_q;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : g_bit
			// A new level is taken only when the second and third stages agree.
			always @(posedge ref_clk or posedge rst)
			begin
				if (rst)
				begin
					st1_q[i] <= RST_VAL[i];
					st2_q[i] <= RST_VAL[i];
					st3_q[i] <= RST_VAL[i];
					clean_q[i] <= RST_VAL[i];
				end
				else
				begin
					st1_q[i] <= pin_in[i];
					st2_q[i] <= st1_q[i];
					st3_q[i] <= st2_q[i];
					if (st2_q[i] == st3_q[i])
						clean_q[i] <= st3_q[i];
				end
			end
		end
	endgenerate

	assign pin_clean = clean_q;

endmodule

// *** test/isrp_status_rx_sva.sv ***
/* Port checker of the status and receive path. Assumes a bind to isrp_status_rx. */
`timescale 1ns/100ps
module isrp_sva
(
	input wire ref_clk,
	input wire rst,
	input wire [15:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	input wire [7:0] rdata,
	input wire scl_in,
	input wire sda_out,
	input wire sda_oe_n,
	input wire start_issued,
	input wire arb_lost,
	input wire [1:0] role_select
);
	logic [1:0] wr_role_q;
	always @(posedge ref_clk)
		wr_role_q <= wdata[5:4];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_rdata_idle;
		!rd |=> rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not zero");
	property p_sda_low;
		sda_out == 1'b0;
	endproperty
	a_sda_low: assert property (p_sda_low)
		else $error("data pin drives high");
	property p_oe_scl_low;
		$changed(sda_oe_n) |-> !scl_in;
	endproperty
	a_oe_scl_low: assert property (p_oe_scl_low)
		else $error("data enable moved with clock high");
	property p_role_wr;
		wr && addr == 16'hf078 && !arb_lost |=> role_select == wr_role_q;
	endproperty
	a_role_wr: assert property (p_role_wr)
		else $error("role bits not written");
	property p_arb;
		arb_lost && role_select[1] |=> role_select == 2'b00;
	endproperty
	a_arb: assert property (p_arb)
		else $error("role kept after lost arbitration");
	property p_arb_slave;
		arb_lost && !role_select[1] && !wr |=> $stable(role_select);
	endproperty
	a_arb_slave: assert property (p_arb_slave)
		else $error("slave role changed");
	property p_start_empty;
		start_issued ##2 (rd && addr == 16'hf07c) |=> rdata[7];
	endproperty
	a_start_empty: assert property (p_start_empty)
		else $error("empty flag not set by start");
	property p_txw_clr;
		wr && addr == 16'hf07e ##2 (rd && addr == 16'hf07c) |=> rdata[7:6] == 2'b00;
	endproperty
	a_txw_clr: assert property (p_txw_clr)
		else $error("transmit flags kept after write");
endmodule

// *** test/isrp_bus_peer.sv ***
/* Bus master model on the wire. Assumes a pull-up on the data line. */
`timescale 1ns/100ps
module isrp_bus_peer
#(
	parameter HALF_NS = 400
)
(
	output logic scl,
	output logic sda_pull,
	input wire sda
);
	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task start_cond();
	begin
		sda_pull = 1'b1;
		#HALF_NS scl = 1'b0;
	end
	endtask
	// Nine clock pulses, the ninth with the line released for the acknowledge.
	// The line level of each data bit is collected, so a byte sent by the block can be read.
	task send_byte(input logic [7:0] d, output logic ack, output logic [7:0] seen);
		integer i;
	begin
		for (i = 0; i < 9; i = i + 1)
		begin
			#HALF_NS sda_pull = (i < 8) ? !d[7 - i] : 1'b0;
			#HALF_NS scl = 1'b1;
			#HALF_NS ack = sda;
			if (i < 8)
				seen = {seen[6:0], sda};
			scl = 1'b0;
		end
	end
	endtask
	task stop_cond();
	begin
		#HALF_NS sda_pull = 1'b1;
		#HALF_NS scl = 1'b1;
		#HALF_NS sda_pull = 1'b0;
		#HALF_NS;
	end
	endtask
endmodule

// *** test/isrp_status_rx_tb.sv ***
/* Testbench of the status and receive path. Assumes the checker and bus model files. */
`timescale 1ns/100ps
module isrp_status_rx_tb;
	logic ref_clk, rst, wr, rd, start_issued, arb_lost, ack;
	logic [15:0] addr;
	logic [7:0] wdata, v, seen;
	wire [7:0] rdata;
	wire [1:0] role_select;
	wire sda_out, sda_oe_n, irq, scl, sda_pull, sda;
	integer num_errors = 0, total_checks = 0, cycles = 0, i;
	// The open-drain data line idles high through its pull-up.
	assign sda = !(sda_pull || !sda_oe_n);
	isrp_status_rx isrp_status_rx_i (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .start_issued(start_issued), .arb_lost(arb_lost),
		.role_select(role_select), .irq(irq));
	isrp_bus_peer isrp_bus_peer_i (.scl(scl), .sda_pull(sda_pull), .sda(sda));
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = !ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			num_errors = num_errors + 1;
			stop_test();
		end
	end
	////////////////////////////////////////
	task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
	begin
		total_checks = total_checks + 1;
		if (seen !== exp)
		begin
			num_errors = num_errors + 1;
			$display("MISMATCH %s expected %h seen %h", n, exp, seen);
		end
	end
	endtask
	task wr_reg(input logic [15:0] a, input logic [7:0] d);
	begin
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	end
	endtask
	task rc(input logic [15:0] a, input logic [7:0] e, input string n);
	begin
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 v = rdata;
		chk(n, v, e);
	end
	endtask
	task pulse(input logic is_arb);
	begin
		@(posedge ref_clk);
		start_issued <= !is_arb;
		arb_lost <= is_arb;
		@(posedge ref_clk);
		start_issued <= 1'b0;
		arb_lost <= 1'b0;
	end
	endtask
	task ck_irq(input logic e);
	begin
		repeat (2) @(posedge ref_clk);
		#1 chk("irq", {7'h0, irq}, {7'h0, e});
	end
	endtask
	task stop_test();
	begin
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	initial
	begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		start_issued = 1'b0;
		arb_lost = 1'b0;
		addr = 16'h0000;
		wdata = 8'h00;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (6) @(posedge ref_clk);
		rc(16'hf07f, 8'hff, "rx_hold");
		wr_reg(16'hf07f, 8'h5a);
		rc(16'hf07f, 8'hff, "rx_hold");
		rc(16'h0000, 8'h00, "unmapped");
		$display("test reset done");
		wr_reg(16'hf07b, 8'h20);
		pulse(1'b0);
		rc(16'hf07c, 8'h80, "status");
		wr_reg(16'hf07c, 8'hff);
		// Bus pins move half a clock away from the edge that samples them.
		@(negedge ref_clk);
		isrp_bus_peer_i.start_cond();
		isrp_bus_peer_i.send_byte(8'ha5, ack, seen);
		chk("ack", {7'h0, ack}, 8'h00);
		wr_reg(16'hf07b, 8'h21);
		@(negedge ref_clk);
		isrp_bus_peer_i.send_byte(8'h3c, ack, seen);
		chk("ack", {7'h0, ack}, 8'h01);
		isrp_bus_peer_i.stop_cond();
		ck_irq(1'b1);
		wr_reg(16'hf07c, 8'h00);
		rc(16'hf07c, 8'he8, "status");
		wr_reg(16'hf07b, 8'h01);
		ck_irq(1'b0);
		wr_reg(16'hf07b, 8'h21);
		ck_irq(1'b1);
		rc(16'hf07f, 8'ha5, "rx_hold");
		rc(16'hf07f, 8'h3c, "rx_hold");
		ck_irq(1'b0);
		wr_reg(16'hf07e, 8'h55);
		rc(16'hf07c, 8'h08, "status");
		wr_reg(16'hf07c, 8'h00);
		rc(16'hf07c, 8'h00, "status");
		$display("test receive done");
		for (i = 0; i < 4; i = i + 1)
		begin
			wr_reg(16'hf078, {2'b00, i[1:0], 4'h0});
			#1 chk("role", {6'h0, role_select}, i[7:0]);
		end
		rc(16'hf07c, 8'h80, "status");
		pulse(1'b1);
		#1 chk("role", {6'h0, role_select}, 8'h00);
		wr_reg(16'hf078, 8'h10);
		pulse(1'b1);
		#1 chk("role", {6'h0, role_select}, 8'h01);
		$display("test roles done");
		wr_reg(16'hf07e, 8'hc3);
		@(negedge ref_clk);
		isrp_bus_peer_i.start_cond();
		isrp_bus_peer_i.send_byte(8'hff, ack, seen);
		chk("tx_byte", seen, 8'hc3);
		chk("ack", {7'h0, ack}, 8'h01);
		isrp_bus_peer_i.stop_cond();
		rc(16'hf07c, 8'hc8, "status");
		$display("test transmit done");
		stop_test();
	end
endmodule
bind isrp_status_rx isrp_sva isrp_sva_i (.ref_clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
	.scl_in, .sda_out, .sda_oe_n, .start_issued, .arb_lost, .role_select);
